/* rtl/str_crc_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module str_crc_counter
    import str_pkg::*;
#(
    parameter int CNT_W = CRC_CNT_W
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic crcRun,
    input wire logic crcUpdate,
    output logic [CNT_W-1:0] count
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
    } str_cnt_state_t;

    str_cnt_state_t cur_q;
    str_cnt_state_t nxt_d;

    // wrap is free: the add simply overflows back to zero
    always_comb begin
        nxt_d = cur_q;
        if (!crcRun) begin
            nxt_d.count = '0;
        end else if (crcUpdate) begin
            nxt_d.count = cur_q.count + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur_q.count <= CNT_W'(CRC_CNT_RST);
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign count = cur_q.count;

endmodule
`default_nettype wire

/* rtl/str_pkg.sv */
// Summary of operation
// - 4-bit CRC update counter, wraps at 15
// - counter held at zero while CRC off
// - bit 5 reports frame CRC support
// - bits 1:0 carry requested PHY pattern
// - old config revision reads pattern as zero
// - adjust requests shown at two locations
// - writing accept clears request, test started
// - writing refuse clears request, test refused
// - writing zero leaves request flag alone
// - reserved test locations read zero
// - run bit starts/stops CRC next frame
// - one 16-bit CRC per component stored
package str_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_ADJ_LANE01 = 10'h206;
    localparam logic [9:0] IDX_ADJ_LANE23 = 10'h207;
    localparam logic [9:0] IDX_CRC_R_LO = 10'h240;
    localparam logic [9:0] IDX_CRC_R_HI = 10'h241;
    localparam logic [9:0] IDX_CRC_G_LO = 10'h242;
    localparam logic [9:0] IDX_CRC_G_HI = 10'h243;
    localparam logic [9:0] IDX_CRC_B_LO = 10'h244;
    localparam logic [9:0] IDX_CRC_B_HI = 10'h245;
    localparam logic [9:0] IDX_CRC_STATUS = 10'h246;
    localparam logic [9:0] IDX_RSVD_247 = 10'h247;
    localparam logic [9:0] IDX_PATTERN = 10'h248;
    localparam logic [9:0] IDX_RSVD_A_LO = 10'h249;
    localparam logic [9:0] IDX_RSVD_A_HI = 10'h25f;
    localparam logic [9:0] IDX_REPLY = 10'h260;
    localparam logic [9:0] IDX_EDID_SUM = 10'h261;
    localparam logic [9:0] IDX_RSVD_B_LO = 10'h262;
    localparam logic [9:0] IDX_RSVD_B_HI = 10'h26f;
    localparam logic [9:0] IDX_CRC_CTRL = 10'h270;
    localparam logic [9:0] IDX_RSVD_C_LO = 10'h271;
    localparam logic [9:0] IDX_RSVD_C_HI = 10'h27f;

    // field positions and widths
    localparam int CRC_CNT_W = 4;
    localparam int CRC_SUP_BIT = 5;
    localparam int PAT_SEL_W = 2;
    localparam int REPLY_W = 3;
    localparam int REPLY_ACK_BIT = 0;
    localparam int REPLY_NAK_BIT = 1;
    localparam int REPLY_EDID_BIT = 2;
    localparam int CRC_RUN_BIT = 0;

    // values after reset
    localparam logic [CRC_CNT_W-1:0] CRC_CNT_RST = 4'h0;
    localparam logic [REPLY_W-1:0] REPLY_RST = 3'h0;
    localparam logic [7:0] EDID_SUM_RST = 8'h00;
    localparam logic [15:0] CRC_VAL_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // requested physical-layer pattern
    typedef enum logic [PAT_SEL_W-1:0] {
        STR_PAT_NONE,
        STR_PAT_D102,
        STR_PAT_SYMERR,
        STR_PAT_PRBS7
    } str_pattern_t;

endpackage

/* rtl/str_regs.sv */
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module str_regs
    import str_pkg::*;
#(
    parameter logic CFG_REV11 = 1'b1,
    parameter logic CRC_SUPPORTED = 1'b1,
    parameter int AW = 12
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic crcUpdate,
    input wire logic [15:0] crcRedIn,
    input wire logic [15:0] crcGreenIn,
    input wire logic [15:0] crcBlueIn,
    input wire logic [PAT_SEL_W-1:0] phyPatternSelect,
    input wire logic [7:0] adjustReqLane01,
    input wire logic [7:0] adjustReqLane23,
    input wire logic testReqEvent,
    output logic crcRun,
    output logic testReqPending,
    output logic testStarted,
    output logic testRefused,
    output logic edidSumWritten,
    output logic [7:0] edidBlockSum
);

    typedef enum logic {
        STR_BUS_IDLE,
        STR_BUS_ANSWER
    } str_bus_t;

    typedef struct packed {
        str_bus_t bus;
        logic [31:0] rdata;
        logic ready;
        logic slvErr;
        logic crcRun;
        logic [15:0] crcRed;
        logic [15:0] crcGreen;
        logic [15:0] crcBlue;
        logic [REPLY_W-1:0] reply;
        logic [7:0] edidSum;
        logic reqPending;
        logic started;
        logic refused;
    } str_state_t;

    str_state_t cur_q;
    str_state_t nxt_d;

    logic [CRC_CNT_W-1:0] crcCount;
    logic [9:0] regIdx;
    logic accessPhase;
    logic commitWr;
    logic ackWr;
    logic nakWr;
    logic [7:0] rdByte;
    logic mapped;

    // update counter lives in its own small module
    str_crc_counter #(
        .CNT_W(CRC_CNT_W)
    ) u_crc_counter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .crcRun(cur_q.crcRun),
        .crcUpdate(crcUpdate),
        .count(crcCount)
    );

    // word addressing: low two address bits are ignored
    assign regIdx = paddr[11:2];
    assign accessPhase = psel && penable;

    // a write lands only at the edge where pready is seen high
    assign commitWr = accessPhase && cur_q.ready && pwrite;
    assign ackWr = commitWr && (regIdx == IDX_REPLY) && pwdata[REPLY_ACK_BIT];
    assign nakWr = commitWr && (regIdx == IDX_REPLY) && pwdata[REPLY_NAK_BIT];

    // read mux; reserved test space answers zero without error
    always_comb begin
        rdByte = 8'h00;
        mapped = 1'b1;
        if (regIdx == IDX_ADJ_LANE01) begin
            rdByte = adjustReqLane01;
        end else if (regIdx == IDX_ADJ_LANE23) begin
            rdByte = adjustReqLane23;
        end else if (regIdx == IDX_CRC_R_LO) begin
            rdByte = cur_q.crcRed[7:0];
        end else if (regIdx == IDX_CRC_R_HI) begin
            rdByte = cur_q.crcRed[15:8];
        end else if (regIdx == IDX_CRC_G_LO) begin
            rdByte = cur_q.crcGreen[7:0];
        end else if (regIdx == IDX_CRC_G_HI) begin
            rdByte = cur_q.crcGreen[15:8];
        end else if (regIdx == IDX_CRC_B_LO) begin
            rdByte = cur_q.crcBlue[7:0];
        end else if (regIdx == IDX_CRC_B_HI) begin
            rdByte = cur_q.crcBlue[15:8];
        end else if (regIdx == IDX_CRC_STATUS) begin
            rdByte[CRC_CNT_W-1:0] = crcCount;
            rdByte[CRC_SUP_BIT] = CRC_SUPPORTED;
        end else if (regIdx == IDX_RSVD_247) begin
            rdByte = 8'h00;
        end else if (regIdx == IDX_PATTERN) begin
            // an old-revision sink has nothing here
            if (CFG_REV11) begin
                rdByte[PAT_SEL_W-1:0] = phyPatternSelect;
            end else begin
                rdByte = 8'h00;
            end
        end else if (regIdx >= IDX_RSVD_A_LO && regIdx <= IDX_RSVD_A_HI) begin
            rdByte = 8'h00;
        end else if (regIdx == IDX_REPLY) begin
            rdByte[REPLY_W-1:0] = cur_q.reply;
        end else if (regIdx == IDX_EDID_SUM) begin
            rdByte = cur_q.edidSum;
        end else if (regIdx >= IDX_RSVD_B_LO && regIdx <= IDX_RSVD_B_HI) begin
            rdByte = 8'h00;
        end else if (regIdx == IDX_CRC_CTRL) begin
            rdByte[CRC_RUN_BIT] = cur_q.crcRun;
        end else if (regIdx >= IDX_RSVD_C_LO && regIdx <= IDX_RSVD_C_HI) begin
            rdByte = 8'h00;
        end else begin
            mapped = 1'b0;
        end
    end

    // next-state logic for bus answer and all stored registers
    always_comb begin
        nxt_d = cur_q;
        nxt_d.started = 1'b0;
        nxt_d.refused = 1'b0;

        // one wait state: answer in the second access cycle
        case (cur_q.bus)
            STR_BUS_IDLE: begin
                nxt_d.ready = 1'b0;
                nxt_d.slvErr = 1'b0;
                if (accessPhase) begin
                    nxt_d.bus = STR_BUS_ANSWER;
                    nxt_d.ready = 1'b1;
                    nxt_d.slvErr = !mapped;
                    nxt_d.rdata = pwrite ? RDATA_RST : {24'h000000, rdByte};
                end
            end
            STR_BUS_ANSWER: begin
                // master drops penable after the answered edge
                nxt_d.bus = STR_BUS_IDLE;
                nxt_d.ready = 1'b0;
                nxt_d.slvErr = 1'b0;
            end
            default: begin
                nxt_d.bus = STR_BUS_IDLE;
                nxt_d.ready = 1'b0;
                nxt_d.slvErr = 1'b0;
            end
        endcase

        // run bit; the engine acts on it from the next frame
        if (commitWr && regIdx == IDX_CRC_CTRL) begin
            nxt_d.crcRun = pwdata[CRC_RUN_BIT];
        end

        // snapshot of per-component results, only while running
        if (crcUpdate && cur_q.crcRun) begin
            nxt_d.crcRed = crcRedIn;
            nxt_d.crcGreen = crcGreenIn;
            nxt_d.crcBlue = crcBlueIn;
        end

        // reply bits are kept verbatim until overwritten
        if (commitWr && regIdx == IDX_REPLY) begin
            nxt_d.reply = pwdata[REPLY_W-1:0];
        end

        // checksum deposited by the source
        if (commitWr && regIdx == IDX_EDID_SUM) begin
            nxt_d.edidSum = pwdata[7:0];
        end

        // accept beats refuse when both are written together
        if (ackWr) begin
            nxt_d.started = 1'b1;
        end else if (nakWr) begin
            nxt_d.refused = 1'b1;
        end

        // zero bits clear nothing; a new request wins over the clear
        if (ackWr || nakWr) begin
            nxt_d.reqPending = 1'b0;
        end
        if (testReqEvent) begin
            nxt_d.reqPending = 1'b1;
        end
    end

    // single state register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur_q.bus <= STR_BUS_IDLE;
            cur_q.rdata <= RDATA_RST;
            cur_q.ready <= 1'b0;
            cur_q.slvErr <= 1'b0;
            cur_q.crcRun <= 1'b0;
            cur_q.crcRed <= CRC_VAL_RST;
            cur_q.crcGreen <= CRC_VAL_RST;
            cur_q.crcBlue <= CRC_VAL_RST;
            cur_q.reply <= REPLY_RST;
            cur_q.edidSum <= EDID_SUM_RST;
            cur_q.reqPending <= 1'b0;
            cur_q.started <= 1'b0;
            cur_q.refused <= 1'b0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    // every output comes straight from the state register
    assign prdata = cur_q.rdata;
    assign pready = cur_q.ready;
    assign pslverr = cur_q.slvErr;
    assign crcRun = cur_q.crcRun;
    assign testReqPending = cur_q.reqPending;
    assign testStarted = cur_q.started;
    assign testRefused = cur_q.refused;
    assign edidSumWritten = cur_q.reply[REPLY_EDID_BIT];
    assign edidBlockSum = cur_q.edidSum;

endmodule
`default_nettype wire

/* tb/str_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module str_regs_assertions
    import str_pkg::*;
#(
    parameter int AW = 12
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic testReqEvent,
    input wire logic crcRun,
    input wire logic testReqPending,
    input wire logic testStarted,
    input wire logic testRefused,
    input wire logic edidSumWritten,
    input wire logic [7:0] edidBlockSum
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    // completed writes, decoded by register index
    wire [9:0] idx = paddr[11:2];
    wire wr = psel && penable && pready && pwrite;
    wire wrRep = wr && idx == IDX_REPLY;
    AST_ONE_WAIT: assert property (psel && $rose(penable) |=> pready)
        else $error("no answer after one wait state");
    AST_ACCEPT: assert property (
        wrRep && pwdata[0] && !testReqEvent |=> testStarted && !testReqPending)
        else $error("accept write lost");
    AST_REFUSE: assert property (
        wrRep && pwdata[1:0] == 2'b10 && !testReqEvent |=> testRefused && !testReqPending)
        else $error("refuse write lost");
    AST_KEEP: assert property (
        testReqPending && !(wrRep && |pwdata[1:0]) |=> testReqPending)
        else $error("pending flag dropped");
    AST_NO_STRAY: assert property (testStarted |-> $past(wrRep && pwdata[0]))
        else $error("start pulse without accept");
    AST_SUM: assert property (
        wr && idx == IDX_EDID_SUM |=> edidBlockSum == $past(pwdata[7:0]))
        else $error("checksum not stored");
    AST_FLAG: assert property (wrRep |=> edidSumWritten == $past(pwdata[2]))
        else $error("checksum flag not stored");
    AST_RUN: assert property (
        wr && idx == IDX_CRC_CTRL |=> crcRun == $past(pwdata[0]))
        else $error("run bit not stored");
    AST_RSVD: assert property (
        pready && !pwrite && (idx == IDX_RSVD_247
        || (idx >= IDX_RSVD_A_LO && idx <= IDX_RSVD_A_HI)
        || (idx >= IDX_RSVD_B_LO && idx <= IDX_RSVD_B_HI)) |-> prdata == 32'h0)
        else $error("reserved read not zero");
    cover property (testStarted);
    cover property (testRefused);
    cover property (pready && pslverr);
endmodule
bind str_regs str_regs_assertions #(
    .AW(AW)
) u_chk (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .testReqEvent(testReqEvent),
    .crcRun(crcRun),
    .testReqPending(testReqPending),
    .testStarted(testStarted),
    .testRefused(testRefused),
    .edidSumWritten(edidSumWritten),
    .edidBlockSum(edidBlockSum)
);
`default_nettype wire

/* tb/str_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module str_src_model (
    input wire logic clk_sys,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    logic hang = 1'b0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // request held until pready seen; bounded so a dead slave cannot hang us
    task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d,
            output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        hang = (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
    // checksum first, then the flag announcing it
    task automatic send_sum(input logic [7:0] s);
        logic [31:0] rd;
        logic er;
        xfer(1'b1, 10'h261, {24'h0, s}, rd, er);
        xfer(1'b1, 10'h260, 32'h4, rd, er);
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
    import str_pkg::*;
;
    logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, crcUpdate;
    logic testReqEvent, crcRun, testReqPending, testStarted, testRefused, edidSumWritten;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, prdataOld;
    logic [15:0] crcRedIn, crcGreenIn, crcBlueIn;
    logic [1:0] phyPatternSelect;
    logic [7:0] adjustReqLane01, adjustReqLane23, edidBlockSum;
    logic er;
    int num_errors = 0;
    int tests_run = 0;
    str_regs DUT (.*);
    str_src_model src (.*);
    // old-revision sink on the same bus; only its read data is watched
    str_regs #(
        .CFG_REV11(1'b0)
    ) DUT_OLD (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdataOld),
        .pready(),
        .pslverr(),
        .crcUpdate(crcUpdate),
        .crcRedIn(crcRedIn),
        .crcGreenIn(crcGreenIn),
        .crcBlueIn(crcBlueIn),
        .phyPatternSelect(phyPatternSelect),
        .adjustReqLane01(adjustReqLane01),
        .adjustReqLane23(adjustReqLane23),
        .testReqEvent(testReqEvent),
        .crcRun(),
        .testReqPending(),
        .testStarted(),
        .testRefused(),
        .edidSumWritten(),
        .edidBlockSum()
    );
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] i, input logic [31:0] d);
        src.xfer(w, i, d, rd, er);
        if (src.hang) begin
            num_errors++;
            $display("Error at %0t: bus timeout", $time);
            tally_and_finish();
        end
    endtask
    task automatic rdc(input logic [9:0] i, input logic [31:0] e);
        bus(1'b0, i, 32'h0);
        chk(rd, e);
    endtask
    task automatic upd(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            crcUpdate <= 1'b1;
            crcRedIn <= crcRedIn + 16'h0101;
            @(posedge clk_sys);
            crcUpdate <= 1'b0;
        end
    endtask
    task automatic req();
        @(posedge clk_sys);
        testReqEvent <= 1'b1;
        @(posedge clk_sys);
        testReqEvent <= 1'b0;
    endtask
    // 17 updates wrap the counter to 1; stopping forces zero
    task automatic t_crc();
        bus(1'b1, IDX_CRC_CTRL, 32'h1);
        @(negedge clk_sys);
        chk(crcRun, 1'b1);
        upd(17);
        rdc(IDX_CRC_STATUS, 32'h21);
        rdc(IDX_CRC_R_LO, 32'h11);
        rdc(IDX_CRC_R_HI, 32'h11);
        rdc(IDX_CRC_G_HI, 32'hbe);
        rdc(IDX_CRC_B_LO, 32'h0f);
        bus(1'b1, IDX_CRC_CTRL, 32'h0);
        @(negedge clk_sys);
        chk(crcRun, 1'b0);
        upd(1);
        rdc(IDX_CRC_STATUS, 32'h20);
        rdc(IDX_CRC_R_LO, 32'h11);
        $display("t_crc done");
    endtask
    task automatic t_pat();
        for (int p = 0; p < 4; p++) begin
            phyPatternSelect <= p[1:0];
            rdc(IDX_PATTERN, p);
            chk(prdataOld, 32'h0);
        end
        rdc(IDX_ADJ_LANE01, 32'h5a);
        rdc(IDX_ADJ_LANE23, 32'ha5);
        $display("t_pat done");
    endtask
    task automatic t_reply();
        req();
        bus(1'b1, IDX_REPLY, 32'h0);
        @(negedge clk_sys);
        chk(testReqPending, 1'b1);
        bus(1'b1, IDX_REPLY, 32'h1);
        @(negedge clk_sys);
        chk({testStarted, testReqPending}, 2'b10);
        req();
        bus(1'b1, IDX_REPLY, 32'h2);
        @(negedge clk_sys);
        chk({testRefused, testReqPending}, 2'b10);
        rdc(IDX_REPLY, 32'h2);
        src.send_sum(8'h3c);
        @(negedge clk_sys);
        chk({edidSumWritten, edidBlockSum}, 9'h13c);
        bus(1'b1, IDX_REPLY, 32'hfc);
        rdc(IDX_REPLY, 32'h4);
        bus(1'b1, IDX_RSVD_247, 32'hff);
        rdc(IDX_RSVD_247, 32'h0);
        rdc(IDX_RSVD_A_HI, 32'h0);
        rdc(IDX_RSVD_B_LO, 32'h0);
        bus(1'b0, 10'h000, 32'h0);
        chk(er, 1'b1);
        $display("t_reply done");
    endtask
    initial begin
        resetn = 1'b0;
        {crcUpdate, testReqEvent, phyPatternSelect} = '0;
        {crcRedIn, crcGreenIn, crcBlueIn} = {16'h0000, 16'hbeef, 16'h0f0f};
        {adjustReqLane01, adjustReqLane23} = 16'h5aa5;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rdc(IDX_REPLY, 32'h0);
        t_crc();
        t_pat();
        t_reply();
        tally_and_finish();
    end
endmodule
`default_nettype wire
